// [hw/pps_input_select.sv]
// Input side of the peripheral pin routing matrix.
// Notes on behaviour
// - Only digital signals routed; analog stays fixed.
// - Input selection independent of output source selection.
// - One selection register per peripheral input.
// - Large packages reach only two ports per input.
// - Many inputs may share one pin.
// - Port reads return pin levels regardless.
// - Analog select bit disables digital input buffer.
// - Power-on reset loads each default pin code.
// - Port field bits 5:3, pin bits 2:0.
// - Only power-on/brown-out reset restores defaults.
// - Lock flag set ignores selection writes.
`timescale 1ns/1ps
module pps_input_select
	import pps_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic soft_reset,
	input wire logic large_package,
	input wire pps_ports_s pin_in,
	input wire pps_ports_s analog_select_bit,
	input wire logic routing_lock_flag,
	input wire pps_wr_s sel_wr,
	output pps_sel_arr_t peripheral_input_select,
	output logic [PPS_NUM_IN-1:0] periph_in,
	output pps_ports_s port_read
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	pps_ports_s pin_meta_reg;
	pps_ports_s pin_sync_reg;
	logic large_meta_reg;
	logic large_sync_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
		end else begin
			pin_meta_reg <= pin_in;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			large_meta_reg <= 1'b0;
			large_sync_reg <= 1'b0;
		end else begin
			large_meta_reg <= large_package;
			large_sync_reg <= large_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// Digital input buffers
	// ----------------------------------------------------------------
	pps_ports_s digital_lvl;
	pps_ports_s pins_exist;
	pps_mask_arr_t port_masks;

	always_comb begin
		digital_lvl = pin_sync_reg & ~analog_select_bit;
		pins_exist = large_sync_reg ? PPS_PINS_LARGE : PPS_PINS_SMALL;
		port_masks = large_sync_reg ? PPS_MASK_LARGE : PPS_MASK_SMALL;
	end

	// Port reads see the buffer output and never depend on the selections.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_read <= '0;
		end else begin
			port_read <= digital_lvl;
		end
	end

	// ----------------------------------------------------------------
	// Selection registers
	// ----------------------------------------------------------------
	pps_sel_arr_t sel_reg;
	pps_sel_arr_t sel_next;

	// Only the asynchronous power-on/brown-out reset reloads defaults; the
	// soft reset is deliberately ignored here.
	always_comb begin
		sel_next = sel_reg;
		if (sel_wr.en && !routing_lock_flag && (sel_wr.idx < PPS_IDX_W'(PPS_NUM_IN))) begin
			sel_next[sel_wr.idx] = sel_wr.data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sel_reg <= PPS_SEL_DEFAULT;
		end else begin
			sel_reg <= sel_next;
		end
	end

	assign peripheral_input_select = sel_reg;

	// ----------------------------------------------------------------
	// Routing multiplexers
	// ----------------------------------------------------------------
	// Only digitally buffered pin levels enter the matrix, and no output
	// source selection is read or written by this block.
	logic [PPS_NUM_IN-1:0] route_lvl;

	genvar gi;
	generate
		for (gi = 0; gi < PPS_NUM_IN; gi++) begin : g_route
			pps_pin_mux u_mux (
				.levels(digital_lvl),
				.exists(pins_exist),
				.sel(sel_reg[gi]),
				.port_mask(port_masks[gi]),
				.level(route_lvl[gi])
			);
		end
	endgenerate

	// Each input has its own mux, so a shared pin fans out to all of them.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			periph_in <= '0;
		end else begin
			periph_in <= route_lvl;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic init_done_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			init_done_reg <= 1'b0;
		end else begin
			init_done_reg <= 1'b1;
		end
	end

	a_reset_default: assert property (@(posedge clk) disable iff (rst)
		!init_done_reg |-> sel_reg == PPS_SEL_DEFAULT)
		else $error("selection not at default after reset");

	a_lock_holds: assert property (@(posedge clk) disable iff (rst)
		routing_lock_flag |=> sel_reg == $past(sel_reg))
		else $error("selection changed while locked");

	a_write_takes: assert property (@(posedge clk) disable iff (rst)
		sel_wr.en && !routing_lock_flag && sel_wr.idx == PPS_IDX_T1_CLK
		|=> sel_reg[PPS_IDX_T1_CLK] == $past(sel_wr.data))
		else $error("unlocked write not stored");

	a_soft_keeps: assert property (@(posedge clk) disable iff (rst)
		soft_reset && !sel_wr.en |=> $stable(sel_reg))
		else $error("soft reset altered selections");

	a_port_read: assert property (@(posedge clk) disable iff (rst)
		##1 port_read == $past(pin_sync_reg & ~analog_select_bit))
		else $error("port read differs from pin level");

	a_analog_blocks: assert property (@(posedge clk) disable iff (rst)
		analog_select_bit.b[sel_reg[PPS_IDX_EXT_INT].pin]
		&& sel_reg[PPS_IDX_EXT_INT].port == PPS_PORT_B
		|=> !periph_in[PPS_IDX_EXT_INT])
		else $error("analog pin reached a peripheral");

	a_bad_port_low: assert property (@(posedge clk) disable iff (rst)
		sel_reg[PPS_IDX_T0_CLK].port >= PPS_PORT_C ##1 sel_reg[PPS_IDX_T0_CLK].port >= PPS_PORT_C
		|-> !periph_in[PPS_IDX_T0_CLK])
		else $error("unreachable port delivered a level");

	a_shared_pin: assert property (@(posedge clk) disable iff (rst)
		sel_reg[PPS_IDX_CAP1] == sel_reg[PPS_IDX_CAP2]
		|=> periph_in[PPS_IDX_CAP1] == periph_in[PPS_IDX_CAP2])
		else $error("shared pin gave different levels");

	a_route_level: assert property (@(posedge clk) disable iff (rst)
		sel_reg[PPS_IDX_SER_DAT].port == PPS_PORT_C
		|=> periph_in[PPS_IDX_SER_DAT] == $past(digital_lvl.c[sel_reg[PPS_IDX_SER_DAT].pin]))
		else $error("routed level does not follow selected pin");

	a_digital_only: assert property (@(posedge clk) disable iff (rst)
		(analog_select_bit == '1) |=> periph_in == '0)
		else $error("analog pins leaked into the matrix");

	// ----------------------------------------------------------------
	// Assertions on writes, package size, reset outputs and analog port reads
	// ----------------------------------------------------------------
	a_bad_index: assert property (@(posedge clk) disable iff (rst)
		sel_wr.en && (sel_wr.idx >= PPS_IDX_W'(PPS_NUM_IN)) |=> $stable(sel_reg))
		else $error("write with a bad index changed a selection");

	a_write_isolated: assert property (@(posedge clk) disable iff (rst)
		sel_wr.en && sel_wr.idx != PPS_IDX_EXT_INT |=> $stable(sel_reg[PPS_IDX_EXT_INT]))
		else $error("write to another input altered the interrupt selection");

	a_small_no_port_d: assert property (@(posedge clk) disable iff (rst)
		!large_sync_reg && sel_reg[PPS_IDX_SER_SEL].port == PPS_PORT_D
		|=> !periph_in[PPS_IDX_SER_SEL])
		else $error("small package reached port D");

	a_large_port_d: assert property (@(posedge clk) disable iff (rst)
		large_sync_reg && sel_reg[PPS_IDX_SER_SEL].port == PPS_PORT_D
		|=> periph_in[PPS_IDX_SER_SEL] == $past(digital_lvl.d[sel_reg[PPS_IDX_SER_SEL].pin]))
		else $error("large package port D level not routed");

	a_reset_outputs: assert property (@(posedge clk) disable iff (rst)
		!init_done_reg |-> periph_in == '0 && port_read == '0)
		else $error("routed outputs not cleared after reset");

	a_analog_read: assert property (@(posedge clk) disable iff (rst)
		(port_read & $past(analog_select_bit)) == '0)
		else $error("port read saw a pin with its buffer off");

endmodule : pps_input_select

// [hw/pps_pin_mux.sv]
// Multiplexer that picks one pin level for one peripheral input.
`timescale 1ns/1ps
module pps_pin_mux
	import pps_pkg::*;
(
	input wire pps_ports_s levels,
	input wire pps_ports_s exists,
	input wire pps_sel_s sel,
	input wire pps_port_mask_t port_mask,
	output logic level
);

	logic [7:0] lvl_byte;
	logic [7:0] ex_byte;
	logic port_ok;

	always_comb begin
		lvl_byte = pps_port_byte(levels, sel.port);
		ex_byte = pps_port_byte(exists, sel.port);
		port_ok = (sel.port <= PPS_PORT_E) && port_mask[sel.port];
		level = port_ok && ex_byte[sel.pin] && lvl_byte[sel.pin];
	end

endmodule : pps_pin_mux

// [pkg/pps_pkg.sv]
// Package holding the types, defaults and routing masks of the input pin select block.
package pps_pkg;

	// ----------------------------------------------------------------
	// Sizes and field layout
	// ----------------------------------------------------------------
	localparam int PPS_NUM_IN = 13;
	localparam int PPS_NUM_PORTS = 5;
	localparam int PPS_IDX_W = 4;
	localparam logic [2:0] PPS_PORT_A = 3'h0;
	localparam logic [2:0] PPS_PORT_B = 3'h1;
	localparam logic [2:0] PPS_PORT_C = 3'h2;
	localparam logic [2:0] PPS_PORT_D = 3'h3;
	localparam logic [2:0] PPS_PORT_E = 3'h4;

	// ----------------------------------------------------------------
	// Peripheral input indices
	// ----------------------------------------------------------------
	localparam logic [3:0] PPS_IDX_EXT_INT = 4'h0;
	localparam logic [3:0] PPS_IDX_T0_CLK = 4'h1;
	localparam logic [3:0] PPS_IDX_T1_CLK = 4'h2;
	localparam logic [3:0] PPS_IDX_T1_GATE = 4'h3;
	localparam logic [3:0] PPS_IDX_T2_IN = 4'h4;
	localparam logic [3:0] PPS_IDX_CAP1 = 4'h5;
	localparam logic [3:0] PPS_IDX_CAP2 = 4'h6;
	localparam logic [3:0] PPS_IDX_SER_CLK = 4'h7;
	localparam logic [3:0] PPS_IDX_SER_DAT = 4'h8;
	localparam logic [3:0] PPS_IDX_SER_SEL = 4'h9;
	localparam logic [3:0] PPS_IDX_UART_RX = 4'hA;
	localparam logic [3:0] PPS_IDX_UART_CK = 4'hB;
	localparam logic [3:0] PPS_IDX_ADC_TRIG = 4'hC;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] port;
		logic [2:0] pin;
	} pps_sel_s;

	typedef pps_sel_s [PPS_NUM_IN-1:0] pps_sel_arr_t;

	typedef struct packed {
		logic [7:0] e;
		logic [7:0] d;
		logic [7:0] c;
		logic [7:0] b;
		logic [7:0] a;
	} pps_ports_s;

	typedef struct packed {
		logic en;
		logic [PPS_IDX_W-1:0] idx;
		pps_sel_s data;
	} pps_wr_s;

	typedef logic [PPS_NUM_PORTS-1:0] pps_port_mask_t;
	typedef pps_port_mask_t [PPS_NUM_IN-1:0] pps_mask_arr_t;

	// ----------------------------------------------------------------
	// Power-on defaults, entry 0 is the external interrupt
	// ----------------------------------------------------------------
	localparam pps_sel_arr_t PPS_SEL_DEFAULT = {
		6'h0C, 6'h16, 6'h17, 6'h05, 6'h14, 6'h13, 6'h11,
		6'h12, 6'h13, 6'h0D, 6'h10, 6'h04, 6'h08
	};

	// ----------------------------------------------------------------
	// Reachable ports per input, bit 0 is port A
	// ----------------------------------------------------------------
	localparam pps_mask_arr_t PPS_MASK_SMALL = {
		5'h06, 5'h06, 5'h06, 5'h05, 5'h06, 5'h06, 5'h06,
		5'h06, 5'h05, 5'h06, 5'h05, 5'h03, 5'h03
	};
	localparam pps_mask_arr_t PPS_MASK_LARGE = {
		5'h0A, 5'h06, 5'h06, 5'h09, 5'h06, 5'h06, 5'h06,
		5'h06, 5'h05, 5'h06, 5'h05, 5'h03, 5'h03
	};

	// Pins that exist on each port for the two package sizes.
	localparam pps_ports_s PPS_PINS_SMALL = {8'h08, 8'h00, 8'hFF, 8'hFF, 8'hFF};
	localparam pps_ports_s PPS_PINS_LARGE = {8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

	// Returns the byte of one port; codes past port E give zero.
	function automatic logic [7:0] pps_port_byte(input pps_ports_s p, input logic [2:0] port);
		logic [7:0] r;
		r = 8'h00;
		if (port == PPS_PORT_A) begin
			r = p.a;
		end else if (port == PPS_PORT_B) begin
			r = p.b;
		end else if (port == PPS_PORT_C) begin
			r = p.c;
		end else if (port == PPS_PORT_D) begin
			r = p.d;
		end else if (port == PPS_PORT_E) begin
			r = p.e;
		end
		return r;
	endfunction : pps_port_byte

endpackage : pps_pkg

// [tb/pps_periph_model.sv]
// Model of the peripherals that sample their routed inputs.
`timescale 1ns/1ps
module pps_periph_model
	import pps_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire pps_sel_arr_t sel,
	input wire logic [PPS_NUM_IN-1:0] periph_in,
	output logic [PPS_NUM_IN-1:0] seen,
	output pps_sel_s ser_clk_out_sel
);
	// Software keeps the serial clock output on the pin its input uses.
	assign ser_clk_out_sel = sel[PPS_IDX_SER_CLK];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seen <= '0;
		end else begin
			seen <= periph_in;
		end
	end
endmodule : pps_periph_model

// [tb/test_pps_input_select.sv]
// Self-checking bench of the input pin select block.
`timescale 1ns/1ps
module test_pps_input_select
	import pps_pkg::*;
;
	logic clk = 0;
	logic rst = 1;
	logic soft_reset = 0;
	logic large_package = 0;
	pps_ports_s pin_in = '0;
	pps_ports_s analog_select_bit = '0;
	logic routing_lock_flag = 0;
	pps_wr_s sel_wr = '0;
	pps_sel_arr_t sel;
	logic [PPS_NUM_IN-1:0] periph_in;
	logic [PPS_NUM_IN-1:0] seen;
	pps_ports_s port_read;
	pps_sel_s ser_out;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;
	localparam logic [5:0] DEF [13] = '{6'h08, 6'h04, 6'h10, 6'h0D, 6'h13, 6'h12, 6'h11,
		6'h13, 6'h14, 6'h05, 6'h17, 6'h16, 6'h0C};
	pps_input_select pps_input_select_i (.clk(clk), .rst(rst), .soft_reset(soft_reset),
		.large_package(large_package), .pin_in(pin_in), .analog_select_bit(analog_select_bit),
		.routing_lock_flag(routing_lock_flag), .sel_wr(sel_wr),
		.peripheral_input_select(sel), .periph_in(periph_in), .port_read(port_read));
	pps_periph_model pps_periph_model_i (.clk(clk), .rst(rst), .sel(sel),
		.periph_in(periph_in), .seen(seen), .ser_clk_out_sel(ser_out));
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		if (fail_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		checks_done++;
		if (exp !== got) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic wr(logic [3:0] idx, logic [5:0] d);
		@(posedge clk);
		sel_wr <= {1'b1, idx, d};
		@(posedge clk);
		sel_wr <= '0;
		#1;
	endtask : wr
	task automatic t_defaults();
		for (int i = 0; i < 13; i++) chk("default sel", DEF[i], sel[i]);
		chk("sel field", 16'h1, sel[0].port);
		chk("serial clock out pin", DEF[7], ser_out);
	endtask : t_defaults
	// Every input that can reach port B shares pin 5 of it.
	task automatic t_shared();
		for (int i = 0; i < 13; i++) if (!(i inside {2, 4, 9})) wr(4'(i), 6'h0D);
		chk("sel ccp2", 16'h0D, sel[6]);
		chk("sel t1clk kept", 16'h10, sel[2]);
		chk("serial clock out moved", 16'h0D, ser_out);
		@(posedge clk) pin_in.b[5] <= 1'b1;
		tick(4);
		chk("shared pin", 16'h1DEB, periph_in);
		tick(1);
		chk("peripheral view", 16'h1DEB, seen);
		wr(2, 6'h0D);
		tick(1);
		chk("unreachable port", 16'h0, periph_in[2]);
		wr(1, 6'h2D);
		tick(1);
		chk("port code 5", 16'h0, periph_in[1]);
	endtask : t_shared
	task automatic t_analog();
		@(posedge clk) pin_in.b[7] <= 1'b1;
		tick(4);
		chk("port read unselected", 16'h1, port_read.b[7]);
		@(posedge clk) analog_select_bit.b[5] <= 1'b1;
		tick(3);
		chk("analog blocks input", 16'h0, periph_in[0]);
		chk("analog port read", 16'h0, port_read.b[5]);
		chk("analog pin fixed", 16'h1, port_read.b[7]);
		@(posedge clk) analog_select_bit <= '1;
		tick(2);
		chk("all analog inputs", 16'h0, periph_in);
		chk("all analog read", 16'h0, port_read.b);
		@(posedge clk) analog_select_bit <= '0;
		tick(3);
		chk("analog cleared", 16'h1, periph_in[0]);
	endtask : t_analog
	task automatic t_package();
		@(posedge clk) pin_in.d[0] <= 1'b1;
		wr(9, 6'h18);
		tick(4);
		chk("small no port D", 16'h0, periph_in[9]);
		@(posedge clk) large_package <= 1'b1;
		tick(5);
		chk("large port D", 16'h1, periph_in[9]);
		chk("port read D", 16'h1, port_read.d[0]);
	endtask : t_package
	task automatic t_lock_reset();
		@(posedge clk) routing_lock_flag <= 1'b1;
		wr(3, 6'h11);
		chk("locked write", 16'h0D, sel[3]);
		@(posedge clk) routing_lock_flag <= 1'b0;
		wr(4'hD, 6'h11);
		chk("bad index", 16'h0D, sel[3]);
		@(posedge clk) soft_reset <= 1'b1;
		@(posedge clk) soft_reset <= 1'b0;
		tick(2);
		chk("soft reset keeps", 16'h0D, sel[0]);
		@(posedge clk) rst <= 1'b1;
		tick(2);
		chk("rst restores", DEF[0], sel[0]);
		@(posedge clk) rst <= 1'b0;
		tick(1);
		t_defaults();
	endtask : t_lock_reset
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		tick(1);
		t_defaults();
		t_shared();
		t_analog();
		t_package();
		t_lock_reset();
		tally_and_finish();
	end
endmodule : test_pps_input_select
